// file: common/rx_status_consts.svh
// Behaviour
// - Bits 29:16 report bytes moved to host, trailing CRC bytes included.
// - Byte count written only in closing descriptor and only without truncation.
// - Bit 15 is OR of bits 1, 6, 7, 11 and 14.
// - Overflow with next descriptor not held truncates; bit 14 in closing descriptor.
// - Bit 13 reserved: written as zero, ignored on reading.
// - Bit 12 set when real length disagrees with the Length/Type field.
// - Bit 11 set when a frame ends before 64 bytes.
// - Short frames reach host only when forward_faulty_frames is set or the frame was truncated.
// - Bit 10 set when destination is a multicast address.
// - Bit 9 set in the descriptor holding the frame's first buffer.
// - Zero-size buffers are skipped; frame starts in next usable buffer.
// - Bit 8 set in the descriptor holding the frame's final bytes.
// - Ownership returned to host on frame completion or full buffers.
// - Oversize flag above 1518 bytes, 1522 with VLAN; no truncation.
// - Checksum fault on CRC mismatch or receive error during reception.
// - Late collision flag when collision seen after the collision window.
`ifndef RX_STATUS_CONSTS_SVH
`define RX_STATUS_CONSTS_SVH

`define OFF_CTRL        12'h000
`define OFF_INT_STATUS  12'h004
`define OFF_INT_MASK    12'h008
`define OFF_LAST_WORD   12'h00c
`define OFF_FRAME_COUNT 12'h010

`define CTRL_FORWARD_FAULTY 0
`define CTRL_VLAN_ENABLE    1
`define CTRL_RESET          2'h0

`define INT_FRAME_DONE  0
`define INT_TRUNCATED   1
`define INT_SHORT_DROP  2
`define INT_NO_DESC     3
`define INT_RESET       4'h0

`define BIT_OWN         31
`define FL_MSB          29
`define FL_LSB          16
`define BIT_FAULT_SUM   15
`define BIT_TRUNC       14
`define BIT_RESERVED    13
`define BIT_SIZE_MISM   12
`define BIT_SHORT       11
`define BIT_GROUP       10
`define BIT_OPENING     9
`define BIT_CLOSING     8
`define BIT_OVERSIZE    7
`define BIT_LATE_COL    6
`define BIT_CHECKSUM    1

`define MIN_FRAME_BYTES  14'h0040
`define MAX_FRAME_BYTES  14'h05ee
`define MAX_VLAN_BYTES   14'h05f2
`define COUNT_SATURATE   14'h3fff

`endif

// file: common/rx_status_pkg.sv
package rx_status_pkg;

    typedef enum logic [5:0] {
        S_FETCH = 6'h01,
        S_RECV  = 6'h02,
        S_PEEK  = 6'h04,
        S_DRAIN = 6'h08,
        S_CLOSE = 6'h10,
        S_WRITE = 6'h20
    } rx_state_e;

    typedef struct packed {
        logic crc_bad;
        logic mii_error;
        logic late_collision;
        logic length_mismatch;
        logic multicast;
    } frame_end_s;

    typedef struct packed {
        logic        own;
        logic [10:0] buf1_size;
        logic [10:0] buf2_size;
    } desc_s;

    typedef struct packed {
        logic        opening;
        logic        closing;
        logic        truncated;
        logic        short_frame;
        logic        oversize;
        frame_end_s  flags;
        logic [13:0] byte_count;
    } close_s;

endpackage

// file: src/status_word_pack.sv
`timescale 1ns/1ps
`include "rx_status_consts.svh"

module status_word_pack (
    input  rx_status_pkg::close_s info,
    output logic [31:0]           word
);
    logic fin;

    always_comb begin
        fin  = info.closing;
        word = 32'h0000_0000;
        word[`BIT_OWN] = 1'b0;
        if (fin && !info.truncated) begin
            word[`FL_MSB:`FL_LSB] = info.byte_count;
        end
        word[`BIT_TRUNC]     = fin & info.truncated;
        word[`BIT_RESERVED]  = 1'b0;
        word[`BIT_SIZE_MISM] = fin & info.flags.length_mismatch;
        word[`BIT_SHORT]     = fin & info.short_frame;
        word[`BIT_GROUP]     = fin & info.flags.multicast;
        word[`BIT_OPENING]   = info.opening;
        word[`BIT_CLOSING]   = fin;
        word[`BIT_OVERSIZE]  = fin & info.oversize;
        word[`BIT_LATE_COL]  = fin & info.flags.late_collision;
        word[`BIT_CHECKSUM]  = fin & (info.flags.crc_bad | info.flags.mii_error);
        word[`BIT_FAULT_SUM] = word[`BIT_CHECKSUM] | word[`BIT_LATE_COL] |
                               word[`BIT_OVERSIZE] | word[`BIT_SHORT] |
                               word[`BIT_TRUNC];
    end
endmodule

// file: src/frame_length_counter.sv
`timescale 1ns/1ps
`include "rx_status_consts.svh"

module frame_length_counter (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        count_en,
    input  wire logic        clear,
    input  wire logic        vlan_enable,
    output logic [13:0]      byte_count,
    output logic             short_frame,
    output logic             oversize
);
    typedef struct packed {
        logic [13:0] count;
    } cnt_state_s;

    cnt_state_s st_reg;
    cnt_state_s st_next;

    always_comb begin
        st_next = st_reg;
        if (clear) begin
            st_next.count = 14'h0000;
        end else if (count_en && st_reg.count != `COUNT_SATURATE) begin
            st_next.count = st_reg.count + 14'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign byte_count  = st_reg.count;
    assign short_frame = st_reg.count < `MIN_FRAME_BYTES;
    // Length only; the frame itself is never cut for this
    assign oversize    = st_reg.count >
                         (vlan_enable ? `MAX_VLAN_BYTES : `MAX_FRAME_BYTES);
endmodule

// file: src/rx_descriptor_status_writer.sv
`timescale 1ns/1ps
`include "rx_status_consts.svh"

module rx_descriptor_status_writer (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [11:0]                paddr,
    input  wire logic [31:0]                pwdata,
    output logic [31:0]                     prdata,
    output logic                            pready,
    output logic                            pslverr,
    output logic                            desc_req,
    input  wire logic                       desc_valid,
    input  rx_status_pkg::desc_s            desc_in,
    input  wire logic                       rx_valid,
    input  wire logic                       rx_last,
    input  rx_status_pkg::frame_end_s       rx_flags,
    output logic                            rx_ready,
    output logic                            wb_valid,
    output logic [31:0]                     wb_word,
    input  wire logic                       wb_ready,
    output logic                            irq
);
    typedef struct packed {
        rx_status_pkg::rx_state_e  state;
        rx_status_pkg::rx_state_e  after;
        logic [1:0]                ctrl;
        logic [3:0]                int_status;
        logic [3:0]                int_mask;
        logic [31:0]               last_word;
        logic [15:0]               frame_count;
        logic [31:0]               prdata;
        rx_status_pkg::desc_s      cur;
        rx_status_pkg::desc_s      nxt;
        logic [11:0]               fill;
        logic                      in_frame;
        logic                      opened_here;
        logic                      truncated;
        rx_status_pkg::frame_end_s flags;
        logic [31:0]               wb_word;
        logic                      wb_closing;
    } wr_state_s;

    wr_state_s st_reg;
    wr_state_s st_next;

    logic                  take_byte;
    logic                  count_clear;
    logic [13:0]           frame_bytes;
    logic                  frame_short;
    logic                  frame_oversize;
    rx_status_pkg::close_s info;
    logic [31:0]           packed_word;
    logic [3:0]            events;
    logic                  apb_wr;
    logic                  mapped;

    function automatic logic [11:0] buf_capacity(input rx_status_pkg::desc_s d);
        buf_capacity = {1'b0, d.buf1_size} + {1'b0, d.buf2_size};
    endfunction

    function automatic logic addr_mapped(input logic [11:0] a);
        addr_mapped = (a == `OFF_CTRL) || (a == `OFF_INT_STATUS) ||
                      (a == `OFF_INT_MASK) || (a == `OFF_LAST_WORD) ||
                      (a == `OFF_FRAME_COUNT);
    endfunction

    frame_length_counter u_len (
        .pclk        (pclk),
        .presetn     (presetn),
        .count_en    (take_byte),
        .clear       (count_clear),
        .vlan_enable (st_reg.ctrl[`CTRL_VLAN_ENABLE]),
        .byte_count  (frame_bytes),
        .short_frame (frame_short),
        .oversize    (frame_oversize)
    );

    status_word_pack u_pack (
        .info (info),
        .word (packed_word)
    );

    always_comb begin
        info.opening     = st_reg.opened_here;
        info.closing     = (st_reg.state == rx_status_pkg::S_CLOSE);
        info.truncated   = st_reg.truncated;
        info.short_frame = frame_short;
        info.oversize    = frame_oversize;
        info.flags       = st_reg.flags;
        info.byte_count  = frame_bytes;
    end

    // Drain state swallows the rest of a truncated frame
    assign rx_ready  = (st_reg.state == rx_status_pkg::S_DRAIN) ||
                       ((st_reg.state == rx_status_pkg::S_RECV) &&
                        (st_reg.fill < buf_capacity(st_reg.cur)));
    assign take_byte = rx_valid && rx_ready;
    assign count_clear = (st_reg.state == rx_status_pkg::S_CLOSE);
    assign desc_req  = (st_reg.state == rx_status_pkg::S_FETCH) ||
                       (st_reg.state == rx_status_pkg::S_PEEK);
    assign wb_valid  = (st_reg.state == rx_status_pkg::S_WRITE);
    assign wb_word   = st_reg.wb_word;
    assign apb_wr    = psel && penable && pwrite;
    assign mapped    = addr_mapped(paddr);
    assign pready    = 1'b1;
    assign pslverr   = psel && penable && !mapped;
    assign prdata    = st_reg.prdata;
    assign irq       = |(st_reg.int_status & st_reg.int_mask);

    always_comb begin
        st_next = st_reg;
        events  = 4'h0;

        unique case (st_reg.state)
            rx_status_pkg::S_FETCH: begin
                if (desc_valid) begin
                    if (desc_in.own) begin
                        st_next.cur         = desc_in;
                        st_next.fill        = 12'h000;
                        st_next.opened_here = 1'b0;
                        st_next.state       = rx_status_pkg::S_RECV;
                    end else begin
                        events[`INT_NO_DESC] = 1'b1;
                    end
                end
            end
            rx_status_pkg::S_RECV: begin
                if (take_byte) begin
                    st_next.fill = st_reg.fill + 12'h001;
                    if (!st_reg.in_frame) begin
                        st_next.in_frame    = 1'b1;
                        st_next.opened_here = 1'b1;
                    end
                    if (rx_last) begin
                        st_next.flags = rx_flags;
                        st_next.state = rx_status_pkg::S_CLOSE;
                    end
                end else if (st_reg.fill >= buf_capacity(st_reg.cur)) begin
                    if (st_reg.in_frame) begin
                        st_next.state = rx_status_pkg::S_PEEK;
                    end else begin
                        // Zero-size descriptor: hand it back empty
                        st_next.wb_word    = packed_word;
                        st_next.wb_closing = 1'b0;
                        st_next.after      = rx_status_pkg::S_FETCH;
                        st_next.state      = rx_status_pkg::S_WRITE;
                    end
                end
            end
            rx_status_pkg::S_PEEK: begin
                if (desc_valid) begin
                    if (desc_in.own) begin
                        st_next.nxt        = desc_in;
                        st_next.wb_word    = packed_word;
                        st_next.wb_closing = 1'b0;
                        st_next.after      = rx_status_pkg::S_RECV;
                        st_next.state      = rx_status_pkg::S_WRITE;
                    end else begin
                        st_next.truncated = 1'b1;
                        st_next.state     = rx_status_pkg::S_DRAIN;
                    end
                end
            end
            rx_status_pkg::S_DRAIN: begin
                if (take_byte && rx_last) begin
                    st_next.flags = rx_flags;
                    st_next.state = rx_status_pkg::S_CLOSE;
                end
            end
            rx_status_pkg::S_CLOSE: begin
                st_next.in_frame  = 1'b0;
                st_next.truncated = 1'b0;
                if (frame_short && !st_reg.ctrl[`CTRL_FORWARD_FAULTY] &&
                    !st_reg.truncated) begin
                    // Descriptor kept for the next frame; nothing reaches the host
                    st_next.fill        = 12'h000;
                    st_next.opened_here = 1'b0;
                    st_next.state       = rx_status_pkg::S_RECV;
                    events[`INT_SHORT_DROP] = 1'b1;
                end else begin
                    st_next.wb_word    = packed_word;
                    st_next.wb_closing = 1'b1;
                    st_next.after      = rx_status_pkg::S_FETCH;
                    st_next.state      = rx_status_pkg::S_WRITE;
                    events[`INT_TRUNCATED] = st_reg.truncated;
                end
            end
            rx_status_pkg::S_WRITE: begin
                if (wb_ready) begin
                    st_next.last_word = st_reg.wb_word;
                    st_next.state     = st_reg.after;
                    if (st_reg.wb_closing) begin
                        st_next.frame_count = st_reg.frame_count + 16'h0001;
                        events[`INT_FRAME_DONE] = 1'b1;
                    end
                    if (st_reg.after == rx_status_pkg::S_RECV) begin
                        st_next.cur         = st_reg.nxt;
                        st_next.fill        = 12'h000;
                        st_next.opened_here = 1'b0;
                    end
                end
            end
            default: begin
                st_next.state = rx_status_pkg::S_FETCH;
            end
        endcase

        // Set wins over a same-cycle write-one clear
        st_next.int_status = st_reg.int_status | events;
        if (apb_wr) begin
            unique case (paddr)
                `OFF_CTRL:       st_next.ctrl     = pwdata[1:0];
                `OFF_INT_MASK:   st_next.int_mask = pwdata[3:0];
                `OFF_INT_STATUS: st_next.int_status = (st_reg.int_status & ~pwdata[3:0]) | events;
                default:         st_next.ctrl     = st_reg.ctrl;
            endcase
        end

        if (psel && !penable) begin
            unique case (paddr)
                `OFF_CTRL:        st_next.prdata = {30'h0, st_reg.ctrl};
                `OFF_INT_STATUS:  st_next.prdata = {28'h0, st_reg.int_status};
                `OFF_INT_MASK:    st_next.prdata = {28'h0, st_reg.int_mask};
                `OFF_LAST_WORD:   st_next.prdata = st_reg.last_word;
                `OFF_FRAME_COUNT: st_next.prdata = {16'h0, st_reg.frame_count};
                default:          st_next.prdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg            <= '0;
            st_reg.state      <= rx_status_pkg::S_FETCH;
            st_reg.after      <= rx_status_pkg::S_FETCH;
            st_reg.ctrl       <= `CTRL_RESET;
            st_reg.int_status <= `INT_RESET;
            st_reg.int_mask   <= `INT_RESET;
        end else begin
            st_reg <= st_next;
        end
    end
endmodule

// file: testbench/rx_status_chk.sv
`timescale 1ns/1ps
module rx_status_chk (
    input wire logic                rx_valid,
    input wire logic                pclk,
    input wire logic                presetn,
    input wire logic                rx_last,
    input rx_status_pkg::frame_end_s rx_flags,
    input wire logic                rx_ready,
    input wire logic                wb_valid,
    input wire logic [31:0]         wb_word,
    input wire logic                wb_ready
);
    rx_status_pkg::frame_end_s last_flags;
    logic                      closing;

    // Flags latched with the last byte, compared against the closing word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_flags <= '0;
        end else if (rx_valid && rx_ready && rx_last) begin
            last_flags <= rx_flags;
        end
    end
    assign closing = wb_valid && wb_word[8] && !wb_word[14];

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    reserved_zero_a: assert property (wb_valid |-> !wb_word[13])
        else $error("reserved bit written as one");
    fault_sum_a: assert property (wb_valid |-> wb_word[15] ==
        (wb_word[1] | wb_word[6] | wb_word[7] | wb_word[11] | wb_word[14]))
        else $error("fault summary wrong");
    length_gate_a: assert property (wb_valid && (!wb_word[8] || wb_word[14])
        |-> wb_word[29:16] == 14'h0) else $error("length in non-closing word");
    word_hold_a: assert property (wb_valid && !wb_ready |=> wb_valid && $stable(wb_word))
        else $error("status word changed while pending");
    owner_return_a: assert property (wb_valid |-> !wb_word[31])
        else $error("ownership not returned");
    trunc_close_a: assert property (wb_valid && wb_word[14] |-> wb_word[8])
        else $error("truncation outside closing word");
    crc_fault_a: assert property (closing |->
        wb_word[1] == (last_flags.crc_bad | last_flags.mii_error))
        else $error("checksum fault wrong");
    late_col_a: assert property (closing |-> wb_word[6] == last_flags.late_collision)
        else $error("late collision flag wrong");
    mismatch_group_a: assert property (closing |-> wb_word[12] == last_flags.length_mismatch
        && wb_word[10] == last_flags.multicast) else $error("size or group flag wrong");
    close_delay_a: assert property ($rose(wb_valid) && closing |->
        $past(rx_valid && rx_ready && rx_last, 2)) else $error("closing write mistimed");

    cover property (wb_valid && wb_word[14]);
    cover property (closing && wb_word[11]);
    cover property (wb_valid && wb_word[9] && !wb_word[8]);
endmodule

// file: testbench/host_ring_model.sv
`timescale 1ns/1ps
module host_ring_model (
    input  wire logic            pclk,
    input  wire logic            presetn,
    input  wire logic            desc_req,
    input  wire logic            wb_valid,
    input  wire logic            slow,
    output logic                 desc_valid,
    output rx_status_pkg::desc_s desc_in,
    output logic                 wb_ready
);
    rx_status_pkg::desc_s q[$];
    logic [1:0]           wait_cnt;

    // Host hands descriptors over one by one; an empty ring reads as not owned
    task automatic post(input rx_status_pkg::desc_s d);
        q.push_back(d);
    endtask

    assign desc_valid = desc_req;
    // Slow host holds off the write-back two cycles
    assign wb_ready = wb_valid && (!slow || wait_cnt == 2'h2);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_cnt <= 2'h0;
            desc_in <= '0;
        end else begin
            if (desc_req && desc_valid && desc_in.own) begin
                void'(q.pop_front());
            end
            wait_cnt <= (wb_valid && !wb_ready) ? wait_cnt + 2'h1 : 2'h0;
            // Stale memory flips both sizes each cycle; after reset they swing between zero and all ones
            desc_in <= (q.size() != 0) ? q[0] :
                {1'b0, ~desc_in.buf1_size, ~desc_in.buf2_size};
        end
    end
endmodule

// file: testbench/tb.sv
`timescale 1ns/1ps
`define CHK(g, x) begin compares++; if ((g) !== (x)) begin fails++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x); end end
module tb;
    logic                      pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic [11:0]               paddr;
    logic [31:0]               pwdata, prdata, wb_word, r, w;
    logic                      desc_req, desc_valid, rx_valid, rx_last, rx_ready;
    logic                      wb_valid, wb_ready, irq, slow;
    rx_status_pkg::desc_s      desc_in;
    rx_status_pkg::frame_end_s rx_flags;
    logic [31:0]               wq[$];
    int                        fails = 0, compares = 0, cycles = 0;
    typedef struct {int len; logic [4:0] f;} row_s;
    row_s rows[8] = '{'{64, 5'h0}, '{63, 5'h0}, '{1518, 5'h0}, '{1519, 5'h0},
                      '{80, 5'h10}, '{80, 5'h08}, '{80, 5'h04}, '{80, 5'h03}};

    rx_descriptor_status_writer rx_descriptor_status_writer_i (.pclk, .presetn, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .desc_req,
        .desc_valid, .desc_in, .rx_valid, .rx_last, .rx_flags, .rx_ready, .wb_valid,
        .wb_word, .wb_ready, .irq);
    host_ring_model host_ring_model_i (.pclk, .presetn, .desc_req, .wb_valid, .slow,
        .desc_valid, .desc_in, .wb_ready);

    initial begin
        pclk = 0;
        forever #25 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        if (wb_valid && wb_ready) wq.push_back(wb_word);
        cycles++;
        if (cycles == 20000) begin
            fails++;
            finish_test();
        end
    end

    function automatic logic [31:0] exp_word(int len, logic [4:0] f);
        logic sh, ov, crc;
        sh = len < 64;
        ov = len > 1518;
        crc = f[4] | f[3];
        return {2'b00, len[13:0], crc | f[2] | ov | sh, 2'b00, f[1], sh, f[0], 2'b11,
                ov, f[2], 4'h0, crc, 1'b0};
    endfunction

    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        e = pslverr;
        r = prdata;
        psel <= 0; penable <= 0;
    endtask

    task send(input int n, input logic [4:0] f);
        for (int i = 0; i < n; i++) begin
            @(posedge pclk);
            rx_valid <= 1; rx_last <= (i == n - 1); rx_flags <= f;
            @(negedge pclk);
            while (rx_ready !== 1'b1) @(negedge pclk);
        end
        @(posedge pclk);
        rx_valid <= 0; rx_last <= 0;
    endtask

    task post(input logic [10:0] b1, input logic [10:0] b2);
        host_ring_model_i.post('{1'b1, b1, b2});
    endtask

    task take(input logic [31:0] x);
        while (wq.size() == 0) @(posedge pclk);
        w = wq.pop_front();
        `CHK(w, x)
    endtask

    task finish_test;
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        {psel, penable, pwrite, rx_valid, rx_last, slow} = '0;
        paddr = 12'h0; pwdata = 32'h0; rx_flags = '0; presetn = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1;
        apb(0, 12'h004, 32'h0);
        `CHK(r, 32'h8)
        @(negedge pclk);
        `CHK(irq, 1'b0)
        apb(1, 12'h000, 32'h1);
        $display("test reset done");
        foreach (rows[i]) begin
            slow <= i[0];
            post(11'h400, 11'h400);
            send(rows[i].len, rows[i].f);
            take(exp_word(rows[i].len, rows[i].f));
        end
        $display("test table done");
        post(11'h010, 11'h010);
        send(100, 5'h0);
        take(32'h0000c300);
        $display("test truncation done");
        post(11'h010, 11'h010);
        post(11'h190, 11'h0);
        send(40, 5'h0);
        take(32'h00000200);
        take(32'h00288900);
        $display("test spanning done");
        post(11'h0, 11'h0);
        post(11'h400, 11'h0);
        send(64, 5'h0);
        take(32'h0);
        take(32'h00400300);
        $display("test empty buffers done");
        apb(1, 12'h000, 32'h0);
        apb(1, 12'h008, 32'h4);
        apb(1, 12'h004, 32'hf);
        post(11'h400, 11'h400);
        send(10, 5'h0);
        while (irq !== 1'b1) @(posedge pclk);
        repeat (3) @(posedge pclk);
        `CHK(wq.size(), 0)
        apb(0, 12'h004, 32'h0);
        // Idle fetch keeps raising not-owned; set beats the clear
        `CHK(r, 32'hc)
        apb(1, 12'h004, 32'h4);
        @(negedge pclk);
        `CHK(irq, 1'b0)
        send(64, 5'h0);
        take(32'h00400300);
        @(negedge pclk);
        `CHK(irq, 1'b0)
        apb(0, 12'h00c, 32'h0);
        `CHK(r, 32'h00400300)
        apb(0, 12'h020, 32'h0);
        `CHK(e, 1'b1)
        `CHK(r, 32'h0)
        $display("test drop and registers done");
        apb(1, 12'h000, 32'h2);
        post(11'h400, 11'h400);
        post(11'h400, 11'h400);
        send(1522, 5'h0);
        send(1523, 5'h0);
        take(32'h05f20300);
        take(32'h05f38380);
        apb(0, 12'h010, 32'h0);
        `CHK(r, 32'he)
        $display("test vlan limit done");
        finish_test();
    end
endmodule

bind rx_descriptor_status_writer rx_status_chk rx_status_chk_i (.pclk, .presetn, .rx_valid,
    .rx_last, .rx_flags, .rx_ready, .wb_valid, .wb_word, .wb_ready);
